// >>> shared/cmc_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

`define CMC_CTRL_OFS      8'h00
`define CMC_CFG2_OFS      8'h04
`define CMC_CONF_OFS      8'h08
`define CMC_TXCTL_OFS     8'h0C
`define CMC_ISTAT_OFS     8'h10
`define CMC_IMASK_OFS     8'h14
`define CMC_ERRCNT_OFS    8'h18

`define CMC_REQ_LSB       8
`define CMC_REQ_MSB       10
`define CMC_STAT_LSB      5
`define CMC_STAT_MSB      7
`define CMC_WAKFILT_BIT   14

`define CMC_TX_REQUEST_FLAG_BIT     0
`define CMC_TX_ABORTED_FLAG_BIT     1

`define CMC_IRQ_WAKE_BIT  0
`define CMC_IRQ_ABORT_BIT 1
`define CMC_IRQ_MODE_BIT  2
`define CMC_IRQ_W         3

`define CMC_IDLE_BITS     11
`define CMC_CTRL_RST      32'h0000_0480
`define CMC_WAKE_FILT_LEN 4

`endif

// >>> shared/cmc_pkg.sv
// Types of the operating-mode controller
// Assumes cmc_regs.svh is on the include path
package cmc_pkg;

    typedef enum logic [2:0] {
        CMC_MODE_NORMAL  = 3'h0,
        CMC_MODE_DISABLE = 3'h1,
        CMC_MODE_LOOP    = 3'h2,
        CMC_MODE_LISTEN  = 3'h3,
        CMC_MODE_INIT    = 3'h4,
        CMC_MODE_LALL    = 3'h7
    } cmc_mode_t;

    typedef enum logic [1:0] {
        CMC_AX_IDLE = 2'b01,
        CMC_AX_RESP = 2'b10
    } cmc_ax_t;

    typedef struct packed {
        logic        tx_out;
        logic        tx_oe_n;
        logic        rx_use_pin;
        logic        tx_enable;
        logic        rx_enable;
        logic        loopback;
        logic        err_count_en;
        logic        send_ack_err;
        logic        accept_all;
    } cmc_core_ctl_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0]  resp;
    } cmc_rd_t;

endpackage

// >>> rtl/cmc_mode_ctrl.sv
// CAN operating-mode controller with an AXI4-Lite register slave
// Assumes the frame engine supplies tx_busy, the error strobe and the
// internal transmit bit; the bus receive pin comes from outside and is synchronised
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "cmc_regs.svh"

module cmc_mode_ctrl #(
    parameter int unsigned IDLE_BITS = `CMC_IDLE_BITS,
    parameter int unsigned FILT_LEN  = `CMC_WAKE_FILT_LEN
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  bus_receive_pin,
    output logic                       bus_transmit_pin,
    output logic                       bus_transmit_oe_n,
    output logic                       bus_pins_released,
    input  wire logic                  bit_tick,
    input  wire logic                  core_tx_bit,
    input  wire logic                  tx_busy,
    input  wire logic                  frame_error,
    input  wire logic                  sleep_active,
    output logic                       core_rx_bit,
    output cmc_pkg::cmc_core_ctl_t     core_ctl,
    output logic                       copy_partial_frame,
    output logic                       tx_start,
    output logic                       irq
);
    import cmc_pkg::*;

    localparam logic [2:0] REQ_RST = 3'h4;

    typedef struct packed {
        cmc_ax_t                  wst;
        cmc_ax_t                  rst;
        logic                     awready;
        logic                     wready;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        cmc_rd_t                  rd;
        logic [2:0]               req;
        cmc_mode_t                mode;
        logic                     wake_filter_enable;
        logic [15:0]              conf;
        logic                     tx_request_flag;
        logic                     tx_aborted_flag;
        logic                     tx_wait;
        logic [`CMC_IRQ_W-1:0]    istat;
        logic [`CMC_IRQ_W-1:0]    imask;
        logic [7:0]               err_cnt;
        logic [3:0]               rec_cnt;
        logic                     rx_s1;
        logic                     rx_s2;
        logic [FILT_LEN-1:0]      filt;
        logic                     rx_filt;
        logic                     rx_prev;
        logic                     txp;
        logic                     txoe_n;
        logic                     rel;
        logic                     crx;
        cmc_core_ctl_t            ctl;
        logic                     copy;
        logic                     start;
        logic                     irq;
    } cmc_state_t;

    cmc_state_t st_r;
    cmc_state_t st_nxt;

    function automatic cmc_mode_t decode_req(input logic [2:0] code);
        unique case (code)
            3'h0:    decode_req = CMC_MODE_NORMAL;
            3'h1:    decode_req = CMC_MODE_DISABLE;
            3'h2:    decode_req = CMC_MODE_LOOP;
            3'h3:    decode_req = CMC_MODE_LISTEN;
            3'h7:    decode_req = CMC_MODE_LALL;
            default: decode_req = CMC_MODE_INIT;
        endcase
    endfunction

    function automatic cmc_core_ctl_t mode_ctl(input cmc_mode_t m);
        cmc_core_ctl_t c;
        c = '0;
        c.tx_oe_n = 1'b1;
        c.tx_out  = 1'b1;
        unique case (m)
            CMC_MODE_NORMAL: begin
                c.tx_enable    = 1'b1;
                c.rx_enable    = 1'b1;
                c.rx_use_pin   = 1'b1;
                c.tx_oe_n      = 1'b0;
                c.err_count_en = 1'b1;
                c.send_ack_err = 1'b1;
            end
            CMC_MODE_LISTEN: begin
                c.rx_enable  = 1'b1;
                c.rx_use_pin = 1'b1;
            end
            CMC_MODE_LALL: begin
                c.rx_enable   = 1'b1;
                c.rx_use_pin  = 1'b1;
                c.accept_all  = 1'b1;
            end
            CMC_MODE_LOOP: begin
                c.tx_enable = 1'b1;
                c.rx_enable = 1'b1;
                c.loopback  = 1'b1;
            end
            CMC_MODE_DISABLE, CMC_MODE_INIT:
                c.rx_enable = 1'b0;
            default: c.rx_enable = 1'b0;
        endcase
        mode_ctl = c;
    endfunction

    logic      wr_go;
    logic      rd_go;
    logic      idle_bus;
    logic      recessive;
    logic [`CMC_IRQ_W-1:0] hw_set;
    cmc_mode_t target;
    logic      cfg_ok;
    logic      sw_ok;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.copy  = 1'b0;
        st_nxt.start = 1'b0;
        target   = decode_req(st_r.req);
        cfg_ok   = (st_r.mode == CMC_MODE_INIT);
        wr_go    = st_r.awready && s_axi_awvalid
                   && st_r.wready && s_axi_wvalid;
        rd_go    = st_r.arready && s_axi_arvalid;

        // Receive path: synchroniser then optional wake filter
        st_nxt.rx_s1 = bus_receive_pin;
        st_nxt.rx_s2 = st_r.rx_s1;
        st_nxt.filt  = {st_r.filt[FILT_LEN-2:0], st_r.rx_s2};
        if (st_r.wake_filter_enable &&
            (sleep_active || st_r.mode == CMC_MODE_DISABLE)) begin
            if (&st_r.filt)
                st_nxt.rx_filt = 1'b1;
            else if (~|st_r.filt)
                st_nxt.rx_filt = 1'b0;
        end else begin
            st_nxt.rx_filt = st_r.rx_s2;
        end
        st_nxt.rx_prev = st_r.rx_filt;
        hw_set   = '0;
        hw_set[`CMC_IRQ_WAKE_BIT] = st_r.rx_prev && !st_r.rx_filt
                   && st_r.mode == CMC_MODE_DISABLE;

        // Idle-bus detection: count recessive bits
        recessive = st_r.ctl.loopback ? core_tx_bit : st_r.rx_filt;
        if (bit_tick) begin
            if (!recessive)
                st_nxt.rec_cnt = '0;
            else if (st_r.rec_cnt < 4'(IDLE_BITS))
                st_nxt.rec_cnt = st_r.rec_cnt + 4'h1;
        end
        idle_bus = (st_r.rec_cnt >= 4'(IDLE_BITS));

        // Mode switch
        sw_ok = idle_bus && !(target == CMC_MODE_INIT && tx_busy);
        if (target != st_r.mode && sw_ok) begin
            st_nxt.mode = target;
            hw_set[`CMC_IRQ_MODE_BIT] = 1'b1;
            if (target == CMC_MODE_INIT)
                st_nxt.err_cnt = '0;
            if (target == CMC_MODE_DISABLE && st_r.tx_wait) begin
                st_nxt.tx_wait         = 1'b0;
                st_nxt.tx_request_flag = 1'b0;
                hw_set[`CMC_IRQ_ABORT_BIT] = 1'b1;
            end
        end
        st_nxt.ctl = mode_ctl(st_nxt.mode);

        // Transmit request waits for idle bus before starting
        if (st_r.tx_wait && idle_bus && st_r.ctl.tx_enable
            && target == st_r.mode) begin
            st_nxt.tx_wait = 1'b0;
            st_nxt.start   = 1'b1;
        end
        if (st_r.ctl.err_count_en && frame_error &&
            st_r.err_cnt != 8'hFF)
            st_nxt.err_cnt = st_r.err_cnt + 8'h01;
        if (st_r.ctl.accept_all && frame_error)
            st_nxt.copy = 1'b1;

        // Pins and internal receive
        st_nxt.txp    = st_nxt.ctl.tx_oe_n ? 1'b1 : core_tx_bit;
        st_nxt.txoe_n = st_nxt.ctl.tx_oe_n;
        st_nxt.rel    = !st_nxt.ctl.rx_use_pin &&
                        st_nxt.ctl.tx_oe_n;
        st_nxt.crx    = st_nxt.ctl.loopback ? core_tx_bit
                                            : st_r.rx_filt;

        // AXI write channel
        unique case (st_r.wst)
            CMC_AX_IDLE: begin
                st_nxt.awready = 1'b1;
                st_nxt.wready  = 1'b1;
                if (wr_go) begin
                    st_nxt.awready = 1'b0;
                    st_nxt.wready  = 1'b0;
                    st_nxt.bvalid  = 1'b1;
                    st_nxt.bresp   = 2'b00;
                    st_nxt.wst     = CMC_AX_RESP;
                    unique case (s_axi_awaddr)
                        `CMC_CTRL_OFS: if (s_axi_wstrb[1])
                            st_nxt.req = s_axi_wdata[`CMC_REQ_MSB:`CMC_REQ_LSB];
                        `CMC_CFG2_OFS: if (cfg_ok && s_axi_wstrb[1])
                            st_nxt.wake_filter_enable =
                                s_axi_wdata[`CMC_WAKFILT_BIT];
                        `CMC_CONF_OFS: if (cfg_ok)
                            st_nxt.conf = s_axi_wdata[15:0];
                        `CMC_TXCTL_OFS: if (s_axi_wstrb[0]) begin
                            if (s_axi_wdata[`CMC_TX_REQUEST_FLAG_BIT]) begin
                                st_nxt.tx_request_flag = 1'b1;
                                st_nxt.tx_wait         = 1'b1;
                            end
                            if (s_axi_wdata[`CMC_TX_ABORTED_FLAG_BIT])
                                st_nxt.tx_aborted_flag = 1'b0;
                        end
                        `CMC_ISTAT_OFS: if (s_axi_wstrb[0])
                            st_nxt.istat = st_nxt.istat &
                                ~s_axi_wdata[`CMC_IRQ_W-1:0];
                        `CMC_IMASK_OFS: if (s_axi_wstrb[0])
                            st_nxt.imask = s_axi_wdata[`CMC_IRQ_W-1:0];
                        `CMC_ERRCNT_OFS: st_nxt.bresp = 2'b00;
                        default: st_nxt.bresp = 2'b10;
                    endcase
                end
            end
            CMC_AX_RESP: if (s_axi_bready) begin
                st_nxt.bvalid  = 1'b0;
                st_nxt.awready = 1'b1;
                st_nxt.wready  = 1'b1;
                st_nxt.wst     = CMC_AX_IDLE;
            end
        endcase
        if (st_r.tx_request_flag && st_r.start)
            st_nxt.tx_request_flag = 1'b0;
        // Hardware set wins over a clear in the same cycle
        st_nxt.istat = st_nxt.istat | hw_set;
        st_nxt.tx_aborted_flag |= hw_set[`CMC_IRQ_ABORT_BIT];

        // AXI read channel
        unique case (st_r.rst)
            CMC_AX_IDLE: begin
                st_nxt.arready = 1'b1;
                if (rd_go) begin
                    st_nxt.arready  = 1'b0;
                    st_nxt.rvalid   = 1'b1;
                    st_nxt.rst      = CMC_AX_RESP;
                    st_nxt.rd.resp  = 2'b00;
                    st_nxt.rd.rdata = '0;
                    unique case (s_axi_araddr)
                        `CMC_CTRL_OFS: begin
                            st_nxt.rd.rdata[`CMC_REQ_MSB:`CMC_REQ_LSB] =
                                st_r.req;
                            st_nxt.rd.rdata[`CMC_STAT_MSB:`CMC_STAT_LSB] =
                                st_r.mode;
                        end
                        `CMC_CFG2_OFS: st_nxt.rd.rdata[`CMC_WAKFILT_BIT] =
                            st_r.wake_filter_enable;
                        `CMC_CONF_OFS: st_nxt.rd.rdata[15:0] = st_r.conf;
                        `CMC_TXCTL_OFS: begin
                            st_nxt.rd.rdata[`CMC_TX_REQUEST_FLAG_BIT] =
                                st_r.tx_request_flag;
                            st_nxt.rd.rdata[`CMC_TX_ABORTED_FLAG_BIT] =
                                st_r.tx_aborted_flag;
                        end
                        `CMC_ISTAT_OFS:
                            st_nxt.rd.rdata[`CMC_IRQ_W-1:0] = st_r.istat;
                        `CMC_IMASK_OFS:
                            st_nxt.rd.rdata[`CMC_IRQ_W-1:0] = st_r.imask;
                        `CMC_ERRCNT_OFS: st_nxt.rd.rdata[7:0] = st_r.err_cnt;
                        default: st_nxt.rd.resp = 2'b10;
                    endcase
                end
            end
            CMC_AX_RESP: if (s_axi_rready) begin
                st_nxt.rvalid  = 1'b0;
                st_nxt.arready = 1'b1;
                st_nxt.rst     = CMC_AX_IDLE;
            end
        endcase

        st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r                    <= '0;
            st_r.wst                <= CMC_AX_IDLE;
            st_r.rst                <= CMC_AX_IDLE;
            st_r.req                <= REQ_RST;
            st_r.mode               <= CMC_MODE_INIT;
            st_r.rx_s1              <= 1'b1;
            st_r.rx_s2              <= 1'b1;
            st_r.filt               <= '1;
            st_r.rx_filt            <= 1'b1;
            st_r.rx_prev            <= 1'b1;
            st_r.txp                <= 1'b1;
            st_r.txoe_n             <= 1'b1;
            st_r.rel                <= 1'b1;
            st_r.crx                <= 1'b1;
            st_r.ctl                <= '0;
            st_r.ctl.tx_out         <= 1'b1;
            st_r.ctl.tx_oe_n        <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready      = st_r.awready;
    assign s_axi_wready       = st_r.wready;
    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_arready      = st_r.arready;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rdata        = st_r.rd.rdata;
    assign s_axi_rresp        = st_r.rd.resp;
    assign bus_transmit_pin   = st_r.txp;
    assign bus_transmit_oe_n  = st_r.txoe_n;
    assign bus_pins_released  = st_r.rel;
    assign core_rx_bit        = st_r.crx;
    assign core_ctl           = st_r.ctl;
    assign copy_partial_frame = st_r.copy;
    assign tx_start           = st_r.start;
    assign irq                = st_r.irq;

endmodule // cmc_mode_ctrl

// >>> dv/cmc_bus_node.sv
// Model of the other nodes on the shared bus: bit timing and bus level
// Assumes the bench raises dominant while another node is sending
`timescale 1ns/100ps
module cmc_bus_node #(
    parameter int BIT_CYC = 4
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic dominant,
    output logic      bus_receive_pin,
    output logic      bit_tick
);
    int cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 0;
            bit_tick <= 1'b0;
            bus_receive_pin <= 1'b1;
        end else begin
            bit_tick <= (cnt_r == BIT_CYC - 1);
            cnt_r <= (cnt_r == BIT_CYC - 1) ? 0 : cnt_r + 1;
            if (cnt_r == BIT_CYC - 1) begin
                bus_receive_pin <= !dominant; // Level moves at bit edges
            end
        end
    end
endmodule // cmc_bus_node

// >>> dv/cmc_mode_ctrl_chk.sv
// Assertions on the ports of the operating-mode controller
// Assumes one clock aclk and a synchronous active-low reset
`timescale 1ns/100ps
module cmc_mode_ctrl_chk
    import cmc_pkg::*;
#(
    parameter int unsigned IDLE_BITS = 11
) (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   bus_receive_pin,
    input wire logic                   bus_transmit_pin,
    input wire logic                   bus_transmit_oe_n,
    input wire logic                   bus_pins_released,
    input wire logic                   bit_tick,
    input wire logic                   core_tx_bit,
    input wire logic                   frame_error,
    input wire logic                   core_rx_bit,
    input wire cmc_pkg::cmc_core_ctl_t core_ctl,
    input wire logic                   copy_partial_frame
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       rx_d1_r;
    logic       rx_d2_r;
    logic [4:0] idle_cnt_r;
    // Recessive bit count seen through the same two-stage sync
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_d1_r <= 1'b1;
            rx_d2_r <= 1'b1;
            idle_cnt_r <= 5'h00;
        end else begin
            rx_d1_r <= bus_receive_pin;
            rx_d2_r <= rx_d1_r;
            if (bit_tick && !rx_d2_r) begin
                idle_cnt_r <= 5'h00;
            end else if (bit_tick && idle_cnt_r != 5'h1F) begin
                idle_cnt_r <= idle_cnt_r + 5'h01;
            end
        end
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_ans;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_wr_ans;
        s_wr_take |=> s_wr_ans;
    endproperty
    property p_oe_rel;
        !bus_transmit_oe_n |-> !bus_pins_released;
    endproperty
    property p_tx_rec;
        bus_transmit_oe_n |-> bus_transmit_pin;
    endproperty
    property p_loop_pins;
        core_ctl.loopback |-> bus_pins_released && bus_transmit_oe_n;
    endproperty
    property p_loop_rx;
        core_ctl.loopback && $past(core_ctl.loopback)
            |-> core_rx_bit == $past(core_tx_bit);
    endproperty
    property p_copy;
        frame_error && core_ctl.accept_all |=> copy_partial_frame;
    endproperty
    property p_copy_cause;
        copy_partial_frame |-> $past(frame_error);
    endproperty
    property p_passive;
        !core_ctl.tx_enable |-> !core_ctl.send_ack_err;
    endproperty
    property p_oe_idle;
        $fell(bus_transmit_oe_n) && !$past(core_ctl.loopback, 2)
            |-> idle_cnt_r >= IDLE_BITS;
    endproperty
    property p_rel_idle;
        $rose(bus_pins_released) && !$past(core_ctl.loopback, 2)
            |-> idle_cnt_r >= IDLE_BITS;
    endproperty
    a_wr_ans:
        assert property (p_wr_ans) else $error("write answer late");
    a_oe_rel:
        assert property (p_oe_rel) else $error("driving a released pin");
    a_tx_rec:
        assert property (p_tx_rec) else $error("idle pin not recessive");
    a_loop_pins:
        assert property (p_loop_pins) else $error("loopback holds pins");
    a_loop_rx:
        assert property (p_loop_rx) else $error("loopback data wrong");
    a_copy:
        assert property (p_copy) else $error("partial frame not copied");
    a_copy_cause:
        assert property (p_copy_cause) else $error("copy without error");
    a_passive:
        assert property (p_passive) else $error("passive node answers");
    a_oe_idle:
        assert property (p_oe_idle) else $error("switch on busy bus");
    a_rel_idle:
        assert property (p_rel_idle) else $error("release on busy bus");
endmodule // cmc_mode_ctrl_chk

bind cmc_mode_ctrl cmc_mode_ctrl_chk #(.IDLE_BITS(IDLE_BITS)) i_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .bus_receive_pin, .bus_transmit_pin,
    .bus_transmit_oe_n, .bus_pins_released, .bit_tick, .core_tx_bit,
    .frame_error, .core_rx_bit, .core_ctl, .copy_partial_frame
);

// >>> dv/test_cmc_mode_ctrl.sv
// Self-checking bench of the operating-mode controller
// Assumes the design, bus node model and checker are compiled first
`timescale 1ns/100ps
`include "cmc_regs.svh"
module test_cmc_mode_ctrl;
    import cmc_pkg::*;
    localparam int BC = 4;
    logic          aclk, aresetn, dominant, sleep_active;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata, d, seed, conf_m;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic          s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic          s_axi_rready, bus_receive_pin, bit_tick, core_rx_bit;
    logic          bus_transmit_pin, bus_transmit_oe_n, bus_pins_released;
    logic          core_tx_bit, tx_busy, frame_error;
    logic          copy_partial_frame, tx_start, irq;
    cmc_core_ctl_t core_ctl;
    int            bad_count, compares;
    logic [2:0]    codes [$] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h0};

    cmc_mode_ctrl i_cmc_mode_ctrl (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bus_receive_pin, .bus_transmit_pin,
        .bus_transmit_oe_n, .bus_pins_released, .bit_tick, .core_tx_bit,
        .tx_busy, .frame_error, .sleep_active, .core_rx_bit, .core_ctl,
        .copy_partial_frame, .tx_start, .irq
    );
    cmc_bus_node #(.BIT_CYC(BC)) i_cmc_bus_node (
        .aclk, .aresetn, .dominant, .bus_receive_pin, .bit_tick
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic flag(input int k);
        case (k)
            0: return s_axi_awready;
            1: return s_axi_bvalid;
            2: return s_axi_arready;
            default: return s_axi_rvalid;
        endcase
    endfunction
    // Bounded wait for a handshake flag
    task automatic hs(input int k);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (flag(k) !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            summarize();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        hs(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(1);
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        v = s_axi_rdata;
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask
    // Bit times of bus traffic, optionally with random core activity
    task automatic ticks(input int n, input bit rn);
        logic [31:0] x;
        repeat (n * BC) begin
            @(posedge aclk);
            x = rnd();
            core_tx_bit <= rn ? x[0] : 1'b1;
            frame_error <= rn & x[1] & x[2];
        end
    endtask
    task automatic st(input logic [2:0] c);
        axr(`CMC_CTRL_OFS, d, 2'h0);
        chk("status", 32'(d[7:5]), 32'(c));
    endtask
    task automatic go(input logic [2:0] c);
        axw(`CMC_CTRL_OFS, {21'h0, c, 8'h00}, 2'h0);
        ticks(13, 1'b0);
    endtask

    initial begin
        {aresetn, dominant, sleep_active, tx_busy, frame_error} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, core_tx_bit} = 3'h7;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {bad_count, compares, seed} = {32'h0, 32'h0, 32'h4B};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`CMC_CTRL_OFS, d, 2'h0);
        chk("ctrl_reset", d, `CMC_CTRL_RST);
        axw(8'h1C, 32'h1, 2'h2);
        axr(8'h1C, d, 2'h2);
        chk("unmapped", d, 32'h0);
        conf_m = rnd() & 32'h0000_FFFF;
        axw(`CMC_CONF_OFS, conf_m, 2'h0);
        axw(`CMC_CFG2_OFS, 32'h0000_4000, 2'h0);
        axw(`CMC_IMASK_OFS, 32'h7, 2'h0);
        axr(`CMC_CONF_OFS, d, 2'h0);
        chk("conf_init", d & 32'hFFFF, conf_m);
        axr(`CMC_CFG2_OFS, d, 2'h0);
        chk("wake_filt", 32'(d[14]), 32'h1);
        dominant <= 1'b1;
        go(3'h0);
        st(3'h4);
        dominant <= 1'b0;
        ticks(13, 1'b0);
        st(3'h0);
        chk("oe_n", 32'(bus_transmit_oe_n), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        axw(`CMC_ISTAT_OFS, 32'h7, 2'h0);
        ticks(1, 1'b0);
        chk("irq_clr", 32'(irq), 32'h0);
        axw(`CMC_CONF_OFS, ~conf_m, 2'h0);
        axr(`CMC_CONF_OFS, d, 2'h0);
        chk("conf_lock", d & 32'hFFFF, conf_m);
        tx_busy <= 1'b1;
        go(3'h4);
        st(3'h0);
        tx_busy <= 1'b0;
        ticks(13, 1'b0);
        st(3'h4);
        axr(`CMC_ERRCNT_OFS, d, 2'h0);
        chk("errcnt", d, 32'h0);
        foreach (codes[i]) begin
            go(codes[i]);
            st(codes[i]);
            chk("rel", 32'(bus_pins_released),
                32'(codes[i] inside {3'h1, 3'h2}));
            chk("oe", 32'(bus_transmit_oe_n), 32'(codes[i] != 3'h0));
            if (codes[i] == 3'h1) begin
                axw(`CMC_ISTAT_OFS, 32'h1, 2'h0);
                {sleep_active, dominant} <= 2'h3;
                ticks(4, 1'b0);
                {sleep_active, dominant} <= 2'h0;
                axr(`CMC_ISTAT_OFS, d, 2'h0);
                chk("wake", 32'(d[0]), 32'h1);
            end
            ticks(3, 1'b1);
        end
        dominant <= 1'b1;
        ticks(2, 1'b0);
        axw(`CMC_IMASK_OFS, 32'h0, 2'h0);
        axw(`CMC_ISTAT_OFS, 32'h7, 2'h0);
        axw(`CMC_TXCTL_OFS, 32'h1, 2'h0);
        axw(`CMC_CTRL_OFS, 32'h0000_0100, 2'h0);
        dominant <= 1'b0;
        ticks(13, 1'b0);
        st(3'h1);
        axr(`CMC_TXCTL_OFS, d, 2'h0);
        chk("tx_abort", d & 32'h3, 32'h2);
        axr(`CMC_ISTAT_OFS, d, 2'h0);
        chk("istat", d & 32'h6, 32'h6);
        chk("irq_mask", 32'(irq), 32'h0);
        summarize();
    end
endmodule // test_cmc_mode_ctrl
